//--- src/udc_cfg.svh
// Constants for the up/down event counter block: bit positions, limits, reset values.
// Assumes inclusion by bare name from the package and design files.
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH
`define UDC_BIT_WRAP_LOW   4
`define UDC_BIT_WRAP_HIGH  4
`define UDC_CTRL_WIDTH     16
`define UDC_POS_WRAP_LOW   11
`define UDC_POS_WRAP_HIGH  12
`define UDC_POS_REACHED    13
`define UDC_POS_DOWN_ACT   14
`define UDC_POS_UP_ACT     15
`define UDC_WORD_WIDTH     16
`define UDC_TOTAL_MAX      16'sh7fff
`define UDC_TOTAL_MIN      16'sh8000
`define UDC_TOTAL_RESET    16'sh0000
`define UDC_TARGET_RESET   16'sh0000
`define UDC_NUM_COUNTERS   4
`define UDC_ADDR_WIDTH     4
`endif

//--- src/udc_pkg.sv
// Types shared by the up/down event counter block.
// Assumes the constants header is on the include path.
`include "udc_cfg.svh"
package udc_pkg;
  // Kind of element a clear operation is aimed at
  typedef enum logic [3:0] {
    CLR_NONE    = 4'h1,
    CLR_COUNTER = 4'h2,
    CLR_TIMER   = 4'h4,
    CLR_CONTROL = 4'h8
  } udc_clr_kind_type;
  // Controller mode, one-hot
  typedef enum logic [2:0] {
    MODE_PROGRAM = 3'h1,
    MODE_RUN     = 3'h2,
    MODE_TEST    = 3'h4
  } udc_mode_type;
endpackage

//--- src/udc_cell.sv
// One counter element: control word, target and running total, advanced once per scan.
// Assumes scan_tick pulses once per program scan and the rung inputs are steady around it.
`timescale 1ns/10ps
`include "udc_cfg.svh"
module udc_cell #(
  parameter int W = `UDC_WORD_WIDTH
) (
  input  wire logic         clk_sys,     // System clock
  input  wire logic         rstn,        // Asynchronous reset, active low
  input  wire logic         scan_tick,   // One scan step
  input  wire logic         count_up_op,   // Count-up rung condition
  input  wire logic         count_down_op, // Count-down rung condition
  input  wire logic         clear_hit,   // Clear operation aimed here
  input  wire logic         mode_entry,  // Entering run or test mode
  input  wire logic         target_we,   // Load a new target
  input  wire logic [W-1:0] target_in,   // Target value to load
  output logic [W-1:0]      running_total, // Signed running total
  output logic [W-1:0]      target,        // Signed target value
  output logic [15:0]       ctrl_word      // Status flags
);
  // All state of the cell
  typedef struct packed {
    logic [W-1:0] total;
    logic [W-1:0] tgt;
    logic         up_prev;
    logic         dn_prev;
    logic         wrap_high_flag;
    logic         wrap_low_flag;
    logic         reached_flag;
    logic         up_active_flag;
    logic         down_active_flag;
  } udc_cell_state_type;

  udc_cell_state_type st;       // Registered state
  udc_cell_state_type next_st;  // Next state

  logic         up_edge;        // False-to-true on the up rung
  logic         dn_edge;        // False-to-true on the down rung
  logic [W-1:0] sum;            // Total after this scan's counts

  // Next state; clear beats counting, and the reached flag tracks the new total
  always_comb begin
    next_st = st;
    up_edge = count_up_op && !st.up_prev;
    dn_edge = count_down_op && !st.dn_prev;
    sum     = st.total;
    if (target_we) begin
      next_st.tgt = target_in;
    end
    if (scan_tick) begin
      // Rung history updates every scan so edges are never counted twice
      next_st.up_prev = count_up_op;
      next_st.dn_prev = count_down_op;
      if (clear_hit) begin
        // Clear zeroes total and all flags but reached, which is set when the target is at or below zero, even with the rung enabled
        next_st.total            = `UDC_TOTAL_RESET;
        next_st.wrap_high_flag   = 1'b0;
        next_st.wrap_low_flag    = 1'b0;
        next_st.up_active_flag   = 1'b0;
        next_st.down_active_flag = 1'b0;
        next_st.reached_flag     = ($signed(next_st.tgt) <= 0);
      end else begin
        if (up_edge) begin
          if (sum == `UDC_TOTAL_MAX) begin
            next_st.wrap_high_flag = 1'b1;
          end
          sum = sum + 1'b1;
          if ($signed(sum) >= $signed(`UDC_TOTAL_MAX) || st.total == `UDC_TOTAL_MAX) begin
            next_st.wrap_low_flag = 1'b0;
          end
        end
        if (dn_edge) begin
          if (sum == `UDC_TOTAL_MIN) begin
            next_st.wrap_low_flag = 1'b1;
          end
          if (sum == `UDC_TOTAL_MIN && st.wrap_high_flag) begin
            next_st.wrap_high_flag = 1'b0;
          end
          sum = sum - 1'b1;
        end
        next_st.total            = sum;
        next_st.up_active_flag   = count_up_op;
        next_st.down_active_flag = count_down_op;
        next_st.reached_flag     = ($signed(sum) >= $signed(next_st.tgt));
      end
    end
    if (mode_entry) begin
      next_st.up_active_flag = 1'b1;
    end
  end

  // Register the state; reset only at first power, the cell otherwise retains
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign running_total = st.total;
  assign target        = st.tgt;
  // Three-word element: control word carries the flags
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`UDC_POS_WRAP_LOW]  = st.wrap_low_flag;
    ctrl_word[`UDC_POS_WRAP_HIGH] = st.wrap_high_flag;
    ctrl_word[`UDC_POS_REACHED]   = st.reached_flag;
    ctrl_word[`UDC_POS_DOWN_ACT]  = st.down_active_flag;
    ctrl_word[`UDC_POS_UP_ACT]    = st.up_active_flag;
  end

  // Up edge adds one on the scan it is seen
  chk_up_adds: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && up_edge && !dn_edge && !clear_hit |=> st.total == $past(st.total) + 1'b1)
    else $error("up edge did not add one");
  // Down edge subtracts one
  chk_down_subs: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && dn_edge && !up_edge && !clear_hit |=> st.total == $past(st.total) - 1'b1)
    else $error("down edge did not subtract one");
  // Without an edge or clear the total holds
  chk_total_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(scan_tick && (up_edge || dn_edge || clear_hit)) |=> $stable(st.total))
    else $error("total moved without cause");
  // Wrap at the top sets the high flag
  chk_high_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && up_edge && !dn_edge && !clear_hit && st.total == `UDC_TOTAL_MAX
    |=> st.wrap_high_flag && st.total == `UDC_TOTAL_MIN)
    else $error("high wrap not taken");
  // Wrap at the bottom sets the low flag
  chk_low_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && dn_edge && !up_edge && !clear_hit && st.total == `UDC_TOTAL_MIN
    |=> st.wrap_low_flag && st.total == `UDC_TOTAL_MAX)
    else $error("low wrap not taken");
  // A down wrap back to the top end drops the high flag
  chk_high_return: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && dn_edge && !up_edge && !clear_hit && st.total == `UDC_TOTAL_MIN |=> !st.wrap_high_flag)
    else $error("high flag kept after return");
  // Reached follows the comparison after each scan
  chk_reached_cmp: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && !clear_hit ##1 1'b1 |-> st.reached_flag == ($signed(st.total) >= $signed(st.tgt)))
    else $error("reached flag wrong");
  // Active flags track rung conditions
  chk_active_track: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && !clear_hit && !mode_entry |=> st.up_active_flag == $past(count_up_op)
    && st.down_active_flag == $past(count_down_op))
    else $error("active flag mismatch");
  // Clear zeroes the total and every flag except reached
  sequence s_clear;
    scan_tick && clear_hit && !mode_entry;
  endsequence
  chk_clear_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_clear |=> st.total == '0 && !st.wrap_high_flag && !st.wrap_low_flag
    && !st.up_active_flag && !st.down_active_flag)
    else $error("clear left state behind");
  // Mode entry sets the up-active flag
  chk_mode_up: assert property (@(posedge clk_sys) disable iff (!rstn)
    mode_entry |=> st.up_active_flag)
    else $error("up flag not preset on mode entry");
endmodule

//--- src/udc_top.sv
// Bank of up/down event counters with a shared clear operation, plus one timer and one
// control element that the clear also reaches. Assumes rung inputs are synchronous.
`timescale 1ns/10ps
`include "udc_cfg.svh"

module udc_top #(
  parameter int N  = `UDC_NUM_COUNTERS,
  parameter int AW = `UDC_ADDR_WIDTH,
  parameter int W  = `UDC_WORD_WIDTH
) (
  input  wire logic                     clk_sys,       // System clock, 50 MHz
  input  wire logic                     rstn,          // Asynchronous reset, active low
  input  wire logic                     scan_tick,     // One program scan
  input  wire logic [N-1:0]             count_up_op,   // Count-up rung per counter
  input  wire logic [N-1:0]             count_down_op, // Count-down rung per counter
  input  wire logic                     clear_op,      // Clear operation enabled
  input  wire udc_pkg::udc_clr_kind_type clear_kind,   // Kind of element targeted
  input  wire logic [AW-1:0]            clear_addr,    // Element address targeted
  input  wire udc_pkg::udc_mode_type    mode_req,      // Requested controller mode
  input  wire logic                     target_we,     // Target write strobe
  input  wire logic [AW-1:0]            target_addr,   // Counter for target write
  input  wire logic [W-1:0]             target_in,     // Target value
  input  wire logic [AW-1:0]            read_addr,     // Counter to show
  input  wire logic                     timer_run,     // Timer rung, counts scans
  input  wire logic                     ctl_step,      // Control element step
  output logic [15:0]                   ctrl_out,      // Control word of shown counter
  output logic [W-1:0]                  target_out,    // Target of shown counter
  output logic [W-1:0]                  total_out,     // Total of shown counter
  output logic [W-1:0]                  timer_total,   // Timer running total
  output logic [2:0]                    timer_flags,   // Done, timing, enable
  output logic [W-1:0]                  ctl_pointer,   // Control element pointer
  output logic [7:0]                    ctl_flags      // En, unload-en, done, vacant, fault, unload, hold, found
);
  // All registered state of the top
  typedef struct packed {
    udc_pkg::udc_mode_type mode;
    logic [15:0]  ctrl;
    logic [W-1:0] tgt;
    logic [W-1:0] tot;
    logic [W-1:0] tmr_total;
    logic [2:0]   tmr_flags;
    logic [W-1:0] ptr;
    logic [7:0]   cflags;
  } udc_top_state_type;

  udc_top_state_type st;       // Registered state
  udc_top_state_type next_st;  // Next state

  logic [N-1:0]       clr_hit;      // Per-counter clear decode
  logic [N-1:0]       twe;          // Per-counter target write
  logic               mode_entry;   // Entering run or test
  logic [N*16-1:0]    cw_all;       // Control words flattened
  logic [N*W-1:0]     tg_all;       // Targets flattened
  logic [N*W-1:0]     tt_all;       // Totals flattened
  logic               tmr_hit;      // Clear aimed at the timer
  logic               ctl_hit;      // Clear aimed at the control element

  // Mode entry: a change into run or test from any other mode
  assign mode_entry = (mode_req != st.mode) &&
                      (mode_req == udc_pkg::MODE_RUN || mode_req == udc_pkg::MODE_TEST);
  assign tmr_hit = clear_op && clear_kind == udc_pkg::CLR_TIMER && clear_addr == '0;
  assign ctl_hit = clear_op && clear_kind == udc_pkg::CLR_CONTROL && clear_addr == '0;

  // Counter bank; each cell is one three-word element
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      assign clr_hit[g] = clear_op && clear_kind == udc_pkg::CLR_COUNTER
                          && clear_addr == AW'(g);
      assign twe[g] = target_we && target_addr == AW'(g);
      udc_cell #(.W(W)) u_cell (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .scan_tick     (scan_tick),
        .count_up_op   (count_up_op[g]),
        .count_down_op (count_down_op[g]),
        .clear_hit     (clr_hit[g]),
        .mode_entry    (mode_entry),
        .target_we     (twe[g]),
        .target_in     (target_in),
        .running_total (tt_all[g*W +: W]),
        .target        (tg_all[g*W +: W]),
        .ctrl_word     (cw_all[g*16 +: 16])
      );
    end
  endgenerate

  // Next state: read-back mux, timer and control element upkeep
  always_comb begin
    next_st = st;
    next_st.mode = mode_req;
    // Out-of-range read address shows zeros
    next_st.ctrl = 16'h0000;
    next_st.tgt  = '0;
    next_st.tot  = '0;
    for (int i = 0; i < N; i++) begin
      if (read_addr == AW'(i)) begin
        next_st.ctrl = cw_all[i*16 +: 16];
        next_st.tgt  = tg_all[i*W +: W];
        next_st.tot  = tt_all[i*W +: W];
      end
    end
    // Simple scan-counting timer; flags are done, timing, enable
    if (scan_tick) begin
      if (tmr_hit) begin
        next_st.tmr_total = '0;
        next_st.tmr_flags = 3'h0;
      end else begin
        next_st.tmr_flags[0] = timer_run;
        if (timer_run && st.tmr_total != `UDC_TOTAL_MAX) begin
          next_st.tmr_total = st.tmr_total + 1'b1;
        end
        next_st.tmr_flags[1] = timer_run;
      end
      // Control element: clear keeps hold and found bits
      if (ctl_hit) begin
        next_st.ptr          = '0;
        next_st.cflags[5:0]  = 6'h00;
      end else if (ctl_step) begin
        next_st.ptr       = st.ptr + 1'b1;
        next_st.cflags[0] = 1'b1;
      end
    end
  end

  // Register all state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '{mode: udc_pkg::MODE_PROGRAM, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign ctrl_out    = st.ctrl;
  assign target_out  = st.tgt;
  assign total_out   = st.tot;
  assign timer_total = st.tmr_total;
  assign timer_flags = st.tmr_flags;
  assign ctl_pointer = st.ptr;
  assign ctl_flags   = st.cflags;

  // Clear of the control element keeps hold and found
  chk_ctl_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && ctl_hit |=> st.ptr == '0 && st.cflags[7:6] == $past(st.cflags[7:6]) && st.cflags[5:0] == 6'h00)
    else $error("control clear wrong");
  // Timer clear zeroes everything
  chk_tmr_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && tmr_hit |=> st.tmr_total == '0 ##0 st.tmr_flags == 3'h0)
    else $error("timer clear wrong");
  // Counter clear reaches one cell only
  chk_clear_one: assert property (@(posedge clk_sys) disable iff (!rstn)
    $onehot0(clr_hit))
    else $error("clear hit several counters");
endmodule

//--- tb/udc_rung_model.sv
// Rung logic partner: scan pulses, rung, clear, timer and step conditions.
// Assumes the bench calls phase() from its main thread only.
`timescale 1ns/10ps
module udc_rung_model #(
  parameter int N    = 4, // Counters
  parameter int AW   = 4, // Address width
  parameter int HOLD = 3  // Scans per rung phase
) (
  input  wire logic                 clk_sys,
  output logic                      scan_tick,
  output logic [N-1:0]              count_up_op,
  output logic [N-1:0]              count_down_op,
  output logic                      clear_op,
  output udc_pkg::udc_clr_kind_type clear_kind,
  output logic [AW-1:0]             clear_addr,
  output logic                      timer_run,
  output logic                      ctl_step
);
  // Quiet lines at time zero
  initial begin
    scan_tick     = 1'b0;
    count_up_op   = '0;
    count_down_op = '0;
    clear_op      = 1'b0;
    clear_kind    = udc_pkg::CLR_NONE;
    clear_addr    = '0;
    timer_run     = 1'b0;
    ctl_step      = 1'b0;
  end
  // One phase: same conditions over HOLD scans, so no edge is missed
  task automatic phase(input logic [N-1:0] up, input logic [N-1:0] dn, input logic clr,
                       input udc_pkg::udc_clr_kind_type kind, input logic [AW-1:0] addr,
                       input logic trun, input logic cstep);
    for (int s = 0; s < HOLD; s++) begin
      @(posedge clk_sys);
      scan_tick     <= 1'b1;
      count_up_op   <= up;
      count_down_op <= dn;
      clear_op      <= clr;
      clear_kind    <= kind;
      clear_addr    <= addr;
      timer_run     <= trun;
      ctl_step      <= cstep;
      @(posedge clk_sys);
      // Off-scan levels are not sampled, so they carry noise
      scan_tick     <= 1'b0;
      count_up_op   <= N'($urandom);
      count_down_op <= N'($urandom);
      clear_op      <= 1'($urandom);
      clear_addr    <= AW'($urandom);
      @(posedge clk_sys);
    end
  endtask
endmodule

//--- tb/tb_udc_top.sv
// Bench for the counter bank: reference model, queue of notes, monitor.
// Assumes the package and the rung partner model are compiled first.
`timescale 1ns/10ps
module tb_udc_top;
  localparam int N    = 4;  // Counters
  localparam int AW   = 4;  // Address width
  localparam int W    = 16; // Word width
  localparam int HOLD = 3;  // Scans per phase
  // Expected view: sel 0 a counter, sel 1 timer and control element
  typedef struct {
    logic         sel;
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] c;
  } udc_note_type;
  logic                      clk_sys;
  logic                      rstn;
  logic                      scan_tick;
  logic [N-1:0]              count_up_op;
  logic [N-1:0]              count_down_op;
  logic                      clear_op;
  udc_pkg::udc_clr_kind_type clear_kind;
  logic [AW-1:0]             clear_addr;
  udc_pkg::udc_mode_type     mode_req;
  logic                      target_we;
  logic [AW-1:0]             target_addr;
  logic [W-1:0]              target_in;
  logic [AW-1:0]             read_addr;
  logic                      timer_run;
  logic                      ctl_step;
  logic [15:0]               ctrl_out;
  logic [W-1:0]              target_out;
  logic [W-1:0]              total_out;
  logic [W-1:0]              timer_total;
  logic [2:0]                timer_flags;
  logic [W-1:0]              ctl_pointer;
  logic [7:0]                ctl_flags;
  logic                      look;     // View settled, compare now
  int                        error_cnt;
  int                        total_checks;
  udc_note_type              note_q[$]; // Oldest note first
  udc_note_type              mon_note;
  logic [N-1:0][W-1:0]       r_tot;    // Reference totals
  logic [N-1:0][W-1:0]       r_tgt;    // Reference targets
  logic [N-1:0]              r_ua, r_da, r_rch, r_up, r_dn; // Reference flags, last rungs

  // 50 MHz clock
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  udc_rung_model #(.N(N), .AW(AW), .HOLD(HOLD)) u_udc_rung_model (
    .clk_sys(clk_sys), .scan_tick(scan_tick), .count_up_op(count_up_op),
    .count_down_op(count_down_op), .clear_op(clear_op), .clear_kind(clear_kind),
    .clear_addr(clear_addr), .timer_run(timer_run), .ctl_step(ctl_step));
  udc_top #(.N(N), .AW(AW), .W(W)) u_udc_top (
    .clk_sys(clk_sys), .rstn(rstn), .scan_tick(scan_tick), .count_up_op(count_up_op),
    .count_down_op(count_down_op), .clear_op(clear_op), .clear_kind(clear_kind),
    .clear_addr(clear_addr), .mode_req(mode_req), .target_we(target_we),
    .target_addr(target_addr), .target_in(target_in), .read_addr(read_addr),
    .timer_run(timer_run), .ctl_step(ctl_step), .ctrl_out(ctrl_out),
    .target_out(target_out), .total_out(total_out), .timer_total(timer_total),
    .timer_flags(timer_flags), .ctl_pointer(ctl_pointer), .ctl_flags(ctl_flags));

  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One scan of the reference; wraps are out of reach in this run
  task automatic ref_scan(input logic [N-1:0] up, input logic [N-1:0] dn, input logic clr,
                          input udc_pkg::udc_clr_kind_type kind, input logic [AW-1:0] addr);
    for (int k = 0; k < N; k++) begin
      if (clr && kind == udc_pkg::CLR_COUNTER && addr == AW'(k)) begin
        r_tot[k] = '0;
        r_ua[k]  = 1'b0;
        r_da[k]  = 1'b0;
      end else begin
        // Edge is against the rung seen at the previous scan
        if (up[k] && !r_up[k] && !(dn[k] && !r_dn[k]))
          r_tot[k] = r_tot[k] + 16'h0001;
        if (dn[k] && !r_dn[k] && !(up[k] && !r_up[k]))
          r_tot[k] = r_tot[k] - 16'h0001;
        r_ua[k] = up[k];
        r_da[k] = dn[k];
      end
      r_rch[k] = $signed(r_tot[k]) >= $signed(r_tgt[k]);
    end
    r_up = up;
    r_dn = dn;
  endtask

  // Partner runs one phase; the reference follows scan by scan
  task automatic step(input logic [N-1:0] up, input logic [N-1:0] dn, input logic clr,
                      input udc_pkg::udc_clr_kind_type kind, input logic [AW-1:0] addr,
                      input logic trun);
    u_udc_rung_model.phase(up, dn, clr, kind, addr, trun, trun);
    for (int s = 0; s < HOLD; s++)
      ref_scan(up, dn, clr, kind, addr);
  endtask

  // Note the expected view of every counter, one past the last too
  task automatic check_all();
    for (int k = 0; k <= N; k++) begin
      @(posedge clk_sys);
      read_addr <= AW'(k);
      repeat (3) @(posedge clk_sys);
      if (k < N)
        note_q.push_back('{1'b0, {r_ua[k], r_da[k], r_rch[k], 13'h0000}, r_tgt[k], r_tot[k]});
      else
        note_q.push_back('{1'b0, 16'h0000, 16'h0000, 16'h0000});
      look <= 1'b1;
      @(posedge clk_sys);
      look <= 1'b0;
    end
  endtask

  task automatic set_target(input int k, input logic [W-1:0] v);
    @(posedge clk_sys);
    target_we   <= 1'b1;
    target_addr <= AW'(k);
    target_in   <= v;
    r_tgt[k] = v;
    @(posedge clk_sys);
    target_we   <= 1'b0;
  endtask

  // Used for entries from program mode and for the return to program mode
  task automatic set_mode(input udc_pkg::udc_mode_type m);
    @(posedge clk_sys);
    mode_req <= m;
    if (m != udc_pkg::MODE_PROGRAM)
      r_ua = '1;
  endtask

  // Monitor: on each settled view take the oldest note and compare
  always @(negedge clk_sys) begin
    if (look === 1'b1 && note_q.size() > 0) begin
      mon_note = note_q.pop_front();
      if (mon_note.sel === 1'b0) begin
        check("ctrl_out", ctrl_out, mon_note.a);
        check("target_out", target_out, mon_note.b);
        check("total_out", total_out, mon_note.c);
      end else begin
        check("timer_total", timer_total, mon_note.a);
        check("elem_flags", {5'h00, timer_flags, ctl_flags}, mon_note.b);
        check("ctl_pointer", ctl_pointer, mon_note.c);
      end
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end

  initial begin
    error_cnt    = 0;
    total_checks = 0;
    look         = 1'b0;
    rstn         = 1'b0;
    mode_req     = udc_pkg::MODE_PROGRAM;
    target_we    = 1'b0;
    target_addr  = '0;
    target_in    = '0;
    read_addr    = '0;
    {r_tot, r_tgt, r_ua, r_da, r_rch, r_up, r_dn} = '0;
    void'($urandom(32'hd11989c5));
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    check_all();
    set_mode(udc_pkg::MODE_RUN);
    check_all();
    $display("Test reset and run entry done");
    set_target(0, 16'h0003);
    set_target(1, -W'($urandom_range(1, 100)));
    set_target(2, W'($urandom));
    set_target(3, 16'hfffd);
    step('0, '0, 1'b0, udc_pkg::CLR_NONE, '0, 1'b0);
    check_all();
    // Up on 0 and 2, down on 1 and 3; reached rises and falls at the target
    for (int i = 0; i < 4; i++) begin
      step(4'b0101, 4'b1010, 1'b0, udc_pkg::CLR_NONE, '0, 1'b1);
      check_all();
      step('0, '0, 1'b0, udc_pkg::CLR_NONE, '0, 1'b0);
      check_all();
    end
    $display("Test counting done");
    // Clear counter 1 while its rung and counter 0's rung are true
    step(4'b0001, 4'b0010, 1'b1, udc_pkg::CLR_COUNTER, AW'(1), 1'b0);
    check_all();
    step('0, '0, 1'b0, udc_pkg::CLR_NONE, '0, 1'b0);
    step('0, 4'b0010, 1'b0, udc_pkg::CLR_NONE, '0, 1'b0);
    check_all();
    $display("Test counter clear done");
    step('0, '0, 1'b1, udc_pkg::CLR_TIMER, '0, 1'b0);
    step('0, '0, 1'b1, udc_pkg::CLR_CONTROL, '0, 1'b0);
    @(posedge clk_sys);
    note_q.push_back('{1'b1, 16'h0000, 16'h0000, 16'h0000});
    look <= 1'b1;
    @(posedge clk_sys);
    look <= 1'b0;
    step('0, '0, 1'b1, udc_pkg::CLR_NONE, '0, 1'b0);
    step('0, '0, 1'b1, udc_pkg::CLR_COUNTER, AW'(5), 1'b0);
    check_all();
    $display("Test element clear done");
    set_mode(udc_pkg::MODE_PROGRAM);
    repeat (2) @(posedge clk_sys);
    set_mode(udc_pkg::MODE_TEST);
    check_all();
    $display("Test test entry done");
    test_done();
  end
endmodule
